// ### rtl/irq_flag_pkg.sv
// Purpose: shared constants for the peripheral event flag bank
// Assumes: one core clock, flags packed into one eight-bit flag register image
// Notes: bit positions follow the flag register layout
package irq_flag_pkg;
	localparam int FLAG_W = 8;
	localparam int BIT_WIDE_OVF = 0;
	localparam int BIT_PERIOD = 1;
	localparam int BIT_CAPCOMP = 2;
	localparam int BIT_TX_EMPTY = 4;
	localparam int BIT_SERIAL = 7;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h10;
	localparam int WIDE_W = 16;
	localparam int NARROW_W = 8;

	typedef enum logic [1:0] {
		CC_OFF = 2'b00,
		CC_CAPTURE = 2'b01,
		CC_COMPARE = 2'b10,
		CC_PWM = 2'b11
	} capcomp_mode_e;

	typedef enum logic [1:0] {
		SER_SPI = 2'b00,
		SER_I2C_SLAVE = 2'b01,
		SER_I2C_MASTER = 2'b10,
		SER_DISABLED = 2'b11
	} serial_mode_e;
endpackage

// ### rtl/sticky_flag.sv
// Purpose: one sticky event flag, set by hardware, cleared by software
// Assumes: set and clear are single-cycle strobes on ref_clk
// Notes: set wins over clear so an event in the clearing cycle survives
`timescale 1ns/100ps
module sticky_flag (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// strobes
	input wire logic set,
	input wire logic clear,
	// state
	output logic flag
);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end
endmodule

// ### rtl/peripheral_irq_flag_bank.sv
// Purpose: gathers sticky peripheral event flags and the transmit-buffer status flag into one flag register image
// Assumes: event strobes are one-cycle pulses from logic on ref_clk
// Notes: no bus; firmware clears flags through the clear_mask strobe
// Notes on behaviour
// - transmit-buffer flag reads 0 while the buffer is full, 1 when empty
// - serial-port flag is bit 7, sticky; firmware clears it before leaving service
// - spi or i2c slave/master: byte transfer done sets the serial-port flag
// - i2c master: finished start, restart, stop or acknowledge sets the serial flag
// - multimaster: start or stop seen while serial unit idle sets the flag
// - capture/compare flag is bit 2 and is never set in pwm mode
// - capture mode: timer capture sets the capture/compare flag, sticky until cleared
// - compare mode: wide timer equal to compare value sets the flag, sticky
// - bit 1 set when narrow timer matches its period, sticky until cleared
// - bit 0 set on wide timer overflow, sticky until cleared
`timescale 1ns/100ps
module peripheral_irq_flag_bank (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// modes
	input wire irq_flag_pkg::serial_mode_e serial_mode,
	input wire irq_flag_pkg::capcomp_mode_e capcomp_mode,
	input wire logic multimaster_en,
	// serial events
	input wire logic tx_buffer_full,
	input wire logic serial_xfer_done,
	input wire logic bus_seq_done,
	input wire logic bus_start_seen,
	input wire logic bus_stop_seen,
	input wire logic serial_busy,
	// capture/compare and timers
	input wire logic capture_strobe,
	input wire logic [irq_flag_pkg::WIDE_W-1:0] wide_timer,
	input wire logic [irq_flag_pkg::WIDE_W-1:0] compare_value,
	input wire logic [irq_flag_pkg::NARROW_W-1:0] narrow_timer,
	input wire logic [irq_flag_pkg::NARROW_W-1:0] narrow_timer_period,
	input wire logic wide_timer_overflow,
	// firmware clear, one bit per flag, one-cycle strobe
	input wire logic [irq_flag_pkg::FLAG_W-1:0] clear_mask,
	// flag image
	output logic [irq_flag_pkg::FLAG_W-1:0] flags
);
	import irq_flag_pkg::*;

	// number of image positions that carry a flag, sticky or status
	localparam int FLAG_COUNT = 5;

	// one-hot position of a flag inside the image; out of range gives none
	function automatic logic [FLAG_W-1:0] bit_of(input int pos);
		logic [FLAG_W-1:0] one_hot;
		one_hot = '0;
		if (pos >= 0 && pos < FLAG_W) begin
			one_hot[pos] = 1'b1;
		end
		return one_hot;
	endfunction

	// a held equality counts once: only the cycle in which it begins is an event
	function automatic logic entered_match(input logic now_hit, input logic was_hit);
		return now_hit && !was_hit;
	endfunction

	localparam int POSITIONS [FLAG_COUNT] = '{BIT_SERIAL, BIT_TX_EMPTY, BIT_CAPCOMP, BIT_PERIOD, BIT_WIDE_OVF};

	localparam logic [FLAG_W-1:0] SERIAL_BIT = bit_of(BIT_SERIAL);
	localparam logic [FLAG_W-1:0] TX_EMPTY_BIT = bit_of(BIT_TX_EMPTY);
	localparam logic [FLAG_W-1:0] CAPCOMP_BIT = bit_of(BIT_CAPCOMP);
	localparam logic [FLAG_W-1:0] PERIOD_BIT = bit_of(BIT_PERIOD);
	localparam logic [FLAG_W-1:0] WIDE_OVF_BIT = bit_of(BIT_WIDE_OVF);
	// bit 4 follows the buffer live, so it stays out of the sticky set
	localparam logic [FLAG_W-1:0] STICKY_MASK = SERIAL_BIT | CAPCOMP_BIT | PERIOD_BIT | WIDE_OVF_BIT;
	localparam logic [FLAG_W-1:0] USED_MASK = STICKY_MASK | TX_EMPTY_BIT;

	// refuse layouts and widths that the logic cannot serve
	if (WIDE_W < 1 || NARROW_W < 1) begin : g_bad_timer_width
		$error("timer widths must be positive");
	end
	if (FLAG_W < FLAG_COUNT) begin : g_bad_image_width
		$error("flag image too narrow for its flags");
	end
	// every flag must land inside the image
	for (genvar k = 0; k < FLAG_COUNT; k++) begin : g_position_check
		if (POSITIONS[k] < 0 || POSITIONS[k] >= FLAG_W) begin : g_bad_position
			$error("flag position outside the image");
		end
	end
	if ($countones(USED_MASK) != FLAG_COUNT) begin : g_bad_overlap
		$error("two flags share one image bit");
	end
	// the reset image must agree with the reset value of the status flag
	if (FLAGS_RESET != TX_EMPTY_BIT) begin : g_bad_reset
		$error("reset image must show only an empty transmit buffer");
	end

	// strobes, matches and flag state
	logic serial_set;
	logic capcomp_set;
	logic period_set;
	logic ovf_set;
	logic compare_hit;
	logic period_hit;
	logic compare_hit_q;
	logic period_hit_q;
	logic [FLAG_W-1:0] set_vec;
	logic [FLAG_W-1:0] sticky_vec;
	logic [FLAG_W-1:0] next_flags;
	logic serial_port_event_flag;
	logic capcomp_event_flag;
	logic period_match_flag;
	logic wide_timer_overflow_flag;
	logic tx_buffer_empty_flag;

	// equality is seen combinationally; the edge is taken against last cycle
	assign compare_hit = (wide_timer == compare_value);
	assign period_hit = (narrow_timer == narrow_timer_period);

	// level matches become one event per entry into the match, so a held
	// equality cannot raise again a flag that firmware has just cleared
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_hit_q <= 1'b0;
		end else begin
			compare_hit_q <= compare_hit;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			period_hit_q <= 1'b0;
		end else begin
			period_hit_q <= period_hit;
		end
	end

	// any one of the three causes raises the serial-port flag
	always_comb begin
		serial_set = 1'b0;
		if (serial_mode != SER_DISABLED && serial_xfer_done) begin
			serial_set = 1'b1;
		end
		if (serial_mode == SER_I2C_MASTER && bus_seq_done) begin
			serial_set = 1'b1;
		end
		if (multimaster_en && !serial_busy && (bus_start_seen || bus_stop_seen)) begin
			serial_set = 1'b1;
		end
	end

	// off and pwm leave the flag alone; a flag raised before a switch to pwm stays
	always_comb begin
		case (capcomp_mode)
			CC_CAPTURE: capcomp_set = capture_strobe;
			CC_COMPARE: capcomp_set = entered_match(compare_hit, compare_hit_q);
			default: capcomp_set = 1'b0;
		endcase
	end

	// the period match counts once per entry as well
	assign period_set = entered_match(period_hit, period_hit_q);
	// the overflow arrives as a strobe already, so it needs no edge detect
	assign ovf_set = wide_timer_overflow;

	// gather the set strobes into image positions
	always_comb begin
		set_vec = '0;
		set_vec[BIT_SERIAL] = serial_set;
		set_vec[BIT_CAPCOMP] = capcomp_set;
		set_vec[BIT_PERIOD] = period_set;
		set_vec[BIT_WIDE_OVF] = ovf_set;
	end

	// one sticky cell per sticky position; every other position reads 0
	// inside the cell a set beats a clear of the same cycle
	for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
		if (STICKY_MASK[i]) begin : g_sticky
			sticky_flag u_sticky_flag (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.set(set_vec[i]),
				.clear(clear_mask[i]),
				.flag(sticky_vec[i])
			);
		end else begin : g_plain
			assign sticky_vec[i] = 1'b0;
		end
	end

	assign serial_port_event_flag = sticky_vec[BIT_SERIAL];
	assign capcomp_event_flag = sticky_vec[BIT_CAPCOMP];
	assign period_match_flag = sticky_vec[BIT_PERIOD];
	assign wide_timer_overflow_flag = sticky_vec[BIT_WIDE_OVF];

	// status flag, not sticky: follows the buffer state,
	// so it needs no clear and ignores its clear_mask bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_buffer_empty_flag <= 1'b1;
		end else begin
			tx_buffer_empty_flag <= !tx_buffer_full;
		end
	end

	// image assembled bit by bit; positions without a flag read 0
	always_comb begin
		next_flags = '0;
		next_flags[BIT_SERIAL] = serial_port_event_flag;
		next_flags[BIT_TX_EMPTY] = tx_buffer_empty_flag;
		next_flags[BIT_CAPCOMP] = capcomp_event_flag;
		next_flags[BIT_PERIOD] = period_match_flag;
		next_flags[BIT_WIDE_OVF] = wide_timer_overflow_flag;
	end

	// output image registered so every port comes from a flip-flop;
	// costs one cycle of latency behind the flags
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end
endmodule

// ### test/irq_flag_bank_sva.sv
// Purpose: port checks. Assumes: two-cycle set latency. Notes: bound in the bench
`timescale 1ns/100ps
module irq_flag_bank_sva import irq_flag_pkg::*; (
	input wire logic ref_clk, rst_n, multimaster_en, serial_xfer_done, bus_seq_done, bus_start_seen,
	input wire logic bus_stop_seen, serial_busy, capture_strobe, wide_timer_overflow, tx_buffer_full,
	input wire serial_mode_e serial_mode,
	input wire capcomp_mode_e capcomp_mode,
	input wire logic [7:0] clear_mask, flags
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence up7; ##2 flags[7]; endsequence
	ser_set_a: assert property(serial_xfer_done&&serial_mode!=SER_DISABLED|->up7)else $error("ser");
	seq_set_a: assert property(bus_seq_done&&serial_mode==SER_I2C_MASTER|->up7)else $error("seq");
	bus_cond_a: assert property((bus_start_seen||bus_stop_seen)&&multimaster_en&&!serial_busy|->up7)
		else $error("cond");
	ser_keep_a: assert property($fell(flags[7])|->$past(clear_mask[7],2))else $error("keep");
	pwm_off_a: assert property($rose(flags[2])|->$past(capcomp_mode,2)!=CC_PWM)else $error("pwm");
	cap_set_a: assert property(capture_strobe&&capcomp_mode==CC_CAPTURE|->##2 flags[2])else $error("cap");
	ovf_set_a: assert property(wide_timer_overflow|->##2 flags[0])else $error("ovf");
	tx_lag_a: assert property(flags[4]==!$past(tx_buffer_full,2))else $error("tx");
endmodule

// ### test/fw_model.sv
// Purpose: firmware model. Assumes: go marks a service pass. Notes: one clear strobe, then idle
`timescale 1ns/100ps
module fw_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [7:0] flags,
	output logic [7:0] clear_mask
);
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n) clear_mask<=8'h00;
		else clear_mask<=go&&!clear_mask?flags:8'h00;
endmodule

// ### test/peripheral_irq_flag_bank_tb.sv
// Purpose: random bench. Assumes: partner clears flags. Notes: model checked every cycle
`timescale 1ns/100ps
module peripheral_irq_flag_bank_tb;
	import irq_flag_pkg::*;
	logic ref_clk=0, rst_n=0, go=0, multimaster_en=0, tx_buffer_full=0, serial_xfer_done=0, bus_seq_done=0;
	logic bus_start_seen=0, bus_stop_seen=0, serial_busy=0, capture_strobe=0, wide_timer_overflow=0, t, pw, pn;
	serial_mode_e serial_mode=SER_SPI;
	capcomp_mode_e capcomp_mode=CC_OFF;
	logic [15:0] wide_timer=16'h0001, compare_value=16'h0000;
	logic [7:0] narrow_timer=8'h01, narrow_timer_period=8'h00, clear_mask, flags, st, q;
	logic [31:0] r=32'h0000BEB2;
	int bad_count=0, checked=0;
	peripheral_irq_flag_bank u_peripheral_irq_flag_bank(.*);
	fw_model u_fw_model(.*);
	always #5 ref_clk=~ref_clk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v^=v<<13;
		v^=v>>17;
		return v^(v<<5);
	endfunction
	task automatic complete_run;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count==0&&checked>0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// model: sticky image, then output stage
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n) {st, t, pw, pn, q}=19'h00410;
		else begin
			q={st[7], 2'h0, t, 1'b0, st[2:0]};
			st=st&~clear_mask|{serial_xfer_done&&serial_mode!=SER_DISABLED||
				bus_seq_done&&serial_mode==SER_I2C_MASTER||
				(bus_start_seen||bus_stop_seen)&&multimaster_en&&!serial_busy, 4'h0,
				capture_strobe&&capcomp_mode==CC_CAPTURE||
				wide_timer==compare_value&&!pw&&capcomp_mode==CC_COMPARE,
				narrow_timer==narrow_timer_period&&!pn, wide_timer_overflow};
			{t, pw, pn}={!tx_buffer_full, wide_timer==compare_value, narrow_timer==narrow_timer_period};
		end
	always @(negedge ref_clk) begin
		checked++;
		if (flags!==q) begin
			bad_count++;
			$display("Error %0t flags %h expected %h", $time, flags, q);
		end
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n<=1;
		repeat (3000) begin
			@(posedge ref_clk);
			r=xs(r);
			{go, multimaster_en, tx_buffer_full, serial_xfer_done, bus_seq_done, bus_start_seen, bus_stop_seen,
				serial_busy, capture_strobe, wide_timer_overflow, narrow_timer[1:0], narrow_timer_period[1:0]}<=r[31:18];
			{wide_timer[1:0], compare_value[1:0]}<=r[17:14];
			serial_mode<=serial_mode_e'(r[1:0]);
			capcomp_mode<=capcomp_mode_e'(r[3:2]);
		end
		complete_run();
	end
	initial begin
		#100000;
		bad_count++;
		complete_run();
	end
endmodule
bind peripheral_irq_flag_bank irq_flag_bank_sva u_irq_flag_bank_sva(.ref_clk(ref_clk), .rst_n(rst_n),
	.multimaster_en(multimaster_en), .serial_xfer_done(serial_xfer_done), .bus_seq_done(bus_seq_done),
	.bus_start_seen(bus_start_seen), .bus_stop_seen(bus_stop_seen), .serial_busy(serial_busy),
	.capture_strobe(capture_strobe), .wide_timer_overflow(wide_timer_overflow), .tx_buffer_full(tx_buffer_full),
	.serial_mode(serial_mode), .capcomp_mode(capcomp_mode), .clear_mask(clear_mask), .flags(flags));
